// File: core/lsfb_consts.vh
// Constants for the link status and frame buffer register bank.
// Included by the bank and its octet memory; definitions only.
`ifndef LSFB_CONSTS_VH
`define LSFB_CONSTS_VH
`define LSFB_ADDR_W 5
`define LSFB_OFF_DIO_STATUS 5'h09
`define LSFB_OFF_GLOBAL_STATUS 5'h0A
`define LSFB_OFF_DEFER_CTRL 5'h0F
`define LSFB_OFF_FRAME_FIRST 5'h10
`define LSFB_OFF_FRAME_LAST 5'h1E
`define LSFB_FRAME_OCTETS 15
`define LSFB_FRAME_IDX_W 4
`define LSFB_DIO_ONE_BIT 7
`define LSFB_DIO_LEVEL_BIT 2
`define LSFB_DIO_SHORT_BIT 1
`define LSFB_GS_RESET_BIT 7
`define LSFB_GS_IRQ_BIT 6
`define LSFB_GS_UV_BIT 5
`define LSFB_GS_AUX_IRQ_BIT 4
`define LSFB_GS_CHK_BIT 3
`define LSFB_GS_DATA_BIT 2
`define LSFB_GS_SHORT_BIT 1
`define LSFB_GS_OT_BIT 0
`define LSFB_CNT_LSB 2
`define LSFB_CNT_MSB 5
`define LSFB_CTRL_DECLINE_BIT 1
`define LSFB_CTRL_ARM_BIT 0
`define LSFB_FLAGS_RESET 8'h00
`define LSFB_COUNT_RESET 4'h0
`endif

// File: core/lsfb_octet_mem.v
// Fifteen-octet frame buffer with one register port and one engine port.
// Assumes the host port and the engine never write the same cycle; host wins.
`timescale 1ns/1ps
`include "lsfb_consts.vh"
module lsfb_octet_mem (
   clk,
   sys_rst,
   host_we,
   host_idx,
   host_wdata,
   eng_we,
   eng_idx,
   eng_wdata,
   rd_idx,
   rd_data_q
);
   input wire clk;
   input wire sys_rst;
   input wire host_we;
   input wire [3:0] host_idx;
   input wire [7:0] host_wdata;
   input wire eng_we;
   input wire [3:0] eng_idx;
   input wire [7:0] eng_wdata;
   input wire [3:0] rd_idx;
   output reg [7:0] rd_data_q;

   reg [7:0] mem_q [0:`LSFB_FRAME_OCTETS-1];
   genvar gi;

   generate
      for (gi = 0; gi < `LSFB_FRAME_OCTETS; gi = gi + 1) begin : g_oct
         localparam [3:0] OCT_IDX = gi;
         always @(posedge clk) begin
            if (sys_rst) begin
               mem_q[gi] <= 8'h00;
            end else if (host_we && host_idx == OCT_IDX) begin
               mem_q[gi] <= host_wdata;
            end else if (eng_we && eng_idx == OCT_IDX) begin
               mem_q[gi] <= eng_wdata;
            end
         end
      end
   endgenerate

   always @(posedge clk) begin
      if (sys_rst) begin
         rd_data_q <= 8'h00;
      end else if (rd_idx < `LSFB_FRAME_OCTETS) begin
         rd_data_q <= mem_q[rd_idx];
      end else begin
         rd_data_q <= 8'h00;
      end
   end
endmodule

// File: core/lsfb_regs.v
// Register bank: line status, global status, deferred link control, frame buffer.
// Assumes a byte-wide register port from the serial slave on this clock.
`timescale 1ns/1ps
`include "lsfb_consts.vh"
module lsfb_regs (
   clk,
   sys_rst,
   reg_addr,
   reg_wr,
   reg_rd,
   reg_wdata,
   reg_rdata,
   aux_line_pin,
   short_evt,
   undervoltage_evt,
   aux_line_irq_evt,
   checksum_evt,
   overtemp_evt,
   irq_pending,
   rx_data_available,
   rx_octet_count,
   eng_we,
   eng_idx,
   eng_wdata,
   tx_octet_count,
   tx_start,
   tx_decline
);
   input wire clk;
   input wire sys_rst;
   input wire [4:0] reg_addr;
   input wire reg_wr;
   input wire reg_rd;
   input wire [7:0] reg_wdata;
   output reg [7:0] reg_rdata;
   input wire aux_line_pin;
   input wire short_evt;
   input wire undervoltage_evt;
   input wire aux_line_irq_evt;
   input wire checksum_evt;
   input wire overtemp_evt;
   input wire irq_pending;
   input wire rx_data_available;
   input wire [3:0] rx_octet_count;
   input wire eng_we;
   input wire [3:0] eng_idx;
   input wire [7:0] eng_wdata;
   output reg [3:0] tx_octet_count;
   output reg tx_start;
   output reg tx_decline;

   reg [2:0] lvl_sync_q;
   reg line_level_q;
   reg reset_seen_q;
   reg irq_q;
   reg uv_q;
   reg aux_irq_q;
   reg chk_q;
   reg short_q;
   reg ot_q;
   reg armed_q;
   reg rd_frame_q;
   reg [7:0] rdata_reg_q;
   wire [7:0] mem_rdata;
   wire hit_frame;
   wire [4:0] frame_off;
   wire gs_read;
   wire ctrl_wr;
   wire first_wr;
   reg [7:0] rdata_d;

   assign hit_frame = reg_addr >= `LSFB_OFF_FRAME_FIRST && reg_addr <= `LSFB_OFF_FRAME_LAST;
   assign frame_off = reg_addr - `LSFB_OFF_FRAME_FIRST;
   assign gs_read = reg_rd && reg_addr == `LSFB_OFF_GLOBAL_STATUS;
   assign ctrl_wr = reg_wr && reg_addr == `LSFB_OFF_DEFER_CTRL;
   assign first_wr = reg_wr && reg_addr == `LSFB_OFF_FRAME_FIRST;

   lsfb_octet_mem u_mem (
      .clk(clk),
      .sys_rst(sys_rst),
      .host_we(reg_wr && hit_frame),
      .host_idx(frame_off[3:0]),
      .host_wdata(reg_wdata),
      .eng_we(eng_we),
      .eng_idx(eng_idx),
      .eng_wdata(eng_wdata),
      .rd_idx(frame_off[3:0]),
      .rd_data_q(mem_rdata)
   );

   // Pin level passes three stages; accepted only when the last two agree
   always @(posedge clk) begin
      if (sys_rst) begin
         lvl_sync_q <= 3'h0;
         line_level_q <= 1'b0;
      end else begin
         lvl_sync_q <= {lvl_sync_q[1:0], aux_line_pin};
         if (lvl_sync_q[1] == lvl_sync_q[2]) begin
            line_level_q <= lvl_sync_q[2];
         end
      end
   end

   // Sticky flags: a new event wins over the clear caused by a read
   always @(posedge clk) begin
      if (sys_rst) begin
         reset_seen_q <= 1'b0;
         irq_q <= 1'b0;
         uv_q <= 1'b0;
         aux_irq_q <= 1'b0;
         chk_q <= 1'b0;
         short_q <= 1'b0;
         ot_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == `LSFB_OFF_GLOBAL_STATUS &&
               reg_wdata[`LSFB_GS_RESET_BIT]) begin
            reset_seen_q <= 1'b1;
         end
         irq_q <= irq_pending | (irq_q & ~gs_read);
         uv_q <= undervoltage_evt | (uv_q & ~gs_read);
         aux_irq_q <= aux_line_irq_evt | (aux_irq_q & ~gs_read);
         chk_q <= checksum_evt | (chk_q & ~gs_read);
         short_q <= short_evt | (short_q & ~gs_read);
         ot_q <= overtemp_evt | (ot_q & ~gs_read);
      end
   end

   // Arm waits for the first buffer octet so one burst loads everything
   always @(posedge clk) begin
      if (sys_rst) begin
         tx_octet_count <= `LSFB_COUNT_RESET;
         armed_q <= 1'b0;
         tx_start <= 1'b0;
         tx_decline <= 1'b0;
      end else begin
         tx_start <= 1'b0;
         tx_decline <= 1'b0;
         if (ctrl_wr) begin
            tx_octet_count <= reg_wdata[`LSFB_CNT_MSB:`LSFB_CNT_LSB];
            tx_decline <= reg_wdata[`LSFB_CTRL_DECLINE_BIT];
         end
         if (ctrl_wr && reg_wdata[`LSFB_CTRL_DECLINE_BIT]) begin
            armed_q <= 1'b0;
         end else if (ctrl_wr && reg_wdata[`LSFB_CTRL_ARM_BIT]) begin
            armed_q <= 1'b1;
         end else if (armed_q && first_wr) begin
            armed_q <= 1'b0;
            tx_start <= 1'b1;
         end
      end
   end

   always @* begin
      rdata_d = 8'h00;
      case (reg_addr)
         `LSFB_OFF_DIO_STATUS: begin
            rdata_d[`LSFB_DIO_ONE_BIT] = 1'b1;
            rdata_d[`LSFB_DIO_LEVEL_BIT] = line_level_q;
            rdata_d[`LSFB_DIO_SHORT_BIT] = short_q;
         end
         `LSFB_OFF_GLOBAL_STATUS: begin
            rdata_d[`LSFB_GS_RESET_BIT] = reset_seen_q;
            rdata_d[`LSFB_GS_IRQ_BIT] = irq_q;
            rdata_d[`LSFB_GS_UV_BIT] = uv_q;
            rdata_d[`LSFB_GS_AUX_IRQ_BIT] = aux_irq_q;
            rdata_d[`LSFB_GS_CHK_BIT] = chk_q;
            rdata_d[`LSFB_GS_DATA_BIT] = rx_data_available;
            rdata_d[`LSFB_GS_SHORT_BIT] = short_q;
            rdata_d[`LSFB_GS_OT_BIT] = ot_q;
         end
         `LSFB_OFF_DEFER_CTRL: begin
            // Count reads back the received length, zero when no data waits
            if (rx_data_available) begin
               rdata_d[`LSFB_CNT_MSB:`LSFB_CNT_LSB] = rx_octet_count;
            end
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         rdata_reg_q <= 8'h00;
         rd_frame_q <= 1'b0;
      end else begin
         rd_frame_q <= reg_rd && hit_frame;
         if (reg_rd) begin
            rdata_reg_q <= rdata_d;
         end
      end
   end

   always @* begin
      reg_rdata = rd_frame_q ? mem_rdata : rdata_reg_q;
   end
endmodule

// File: dv/lsfb_regs_properties.sv
// Checker: read layout, count field and send control of the bank.
// Assumes a bind to the bank; sees its ports only.
`timescale 1ns/1ps
module lsfb_regs_props (
   input wire clk,
   input wire sys_rst,
   input wire [4:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire rx_data_available,
   input wire [3:0] rx_octet_count,
   input wire [3:0] tx_octet_count,
   input wire tx_start,
   input wire tx_decline
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   wire rd9 = reg_rd && reg_addr == 5'h09;
   wire rda = reg_rd && reg_addr == 5'h0A;
   wire rdf = reg_rd && reg_addr == 5'h0F;
   wire wrf = reg_wr && reg_addr == 5'h0F;
   property p_dio; rd9 |=> reg_rdata[7] && reg_rdata[6:3] == 4'h0 && !reg_rdata[0]; endproperty
   a_dio: assert property (p_dio) else $error("line status layout");
   property p_dat; rda |=> reg_rdata[2] == $past(rx_data_available); endproperty
   a_dat: assert property (p_dat) else $error("data flag");
   property p_cnt;
      rdf |=> reg_rdata[5:2] == ($past(rx_data_available) ? $past(rx_octet_count) : 4'h0);
   endproperty
   a_cnt: assert property (p_cnt) else $error("count readback");
   property p_ctl; rdf |=> reg_rdata[7:6] == 2'h0 && reg_rdata[1:0] == 2'h0; endproperty
   a_ctl: assert property (p_ctl) else $error("control layout");
   property p_tx; wrf |=> tx_octet_count == $past(reg_wdata[5:2]); endproperty
   a_tx: assert property (p_tx) else $error("transmit count");
   property p_dec; wrf && reg_wdata[1] |=> tx_decline && !tx_start; endproperty
   a_dec: assert property (p_dec) else $error("decline");
   property p_go; tx_start |-> $past(reg_wr && reg_addr == 5'h10); endproperty
   a_go: assert property (p_go) else $error("send without first octet");
   property p_one; tx_start |=> !tx_start; endproperty
   a_one: assert property (p_one) else $error("send pulse width");
   c_go: cover property (tx_start);
   c_dec: cover property (tx_decline);
   c_dat: cover property (rda && rx_data_available);
endmodule
bind lsfb_regs lsfb_regs_props lsfb_regs_props_inst (.*);

// File: dv/lsfb_host.sv
// Host model: one access per call on the byte-wide register port.
// Assumes calls come from one process; write data is inverted when idle, address holds.
`timescale 1ns/1ps
module lsfb_host (
   input wire clk,
   output reg [4:0] reg_addr = 5'h00,
   output reg reg_wr = 1'b0,
   output reg reg_rd = 1'b0,
   output reg [7:0] reg_wdata = 8'h00,
   input wire [7:0] reg_rdata
);
   // Leading edge keeps back-to-back calls from touching a strobe twice in one step
   task acc(input w, input [4:0] a, input [7:0] d, output [7:0] q);
   begin
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = ~d;
      q = reg_rdata;
   end
   endtask
endmodule

// File: dv/test_link_status_frame_buffer_regs.sv
// Bench: host model on the register port, engine side driven here.
// Assumes host model and checker are compiled first.
`timescale 1ns/1ps
module test_link_status_frame_buffer_regs;
   reg clk = 1'b0;
   reg sys_rst = 1'b1;
   reg aux_line_pin = 1'b0;
   reg [5:0] ev = 6'h00;
   reg rx_data_available = 1'b0;
   reg [3:0] rx_octet_count = 4'h0;
   reg eng_we = 1'b0;
   reg [3:0] eng_idx = 4'h0;
   reg [7:0] eng_wdata = 8'h00;
   wire irq_pending, undervoltage_evt, aux_line_irq_evt, checksum_evt, short_evt, overtemp_evt;
   wire [4:0] reg_addr;
   wire reg_wr, reg_rd, tx_start, tx_decline;
   wire [7:0] reg_wdata, reg_rdata;
   wire [3:0] tx_octet_count;
   integer err_total = 0;
   integer checked = 0;
   integer cyc = 0;
   integer i;
   reg [7:0] d;
   assign {irq_pending, undervoltage_evt, aux_line_irq_evt, checksum_evt, short_evt,
      overtemp_evt} = ev;
   lsfb_regs lsfb_regs_inst (.*);
   lsfb_host lsfb_host_inst (.*);
   initial begin
      forever #2.5 clk = ~clk;
   end
   task chk(input [7:0] g, input [7:0] e);
   begin
      checked = checked + 1;
      if (g !== e) begin
         err_total = err_total + 1;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   end
   endtask
   task wr(input [4:0] a, input [7:0] v);
      lsfb_host_inst.acc(1'b1, a, v, d);
   endtask
   task rdc(input [4:0] a, input [7:0] e);
   begin
      lsfb_host_inst.acc(1'b0, a, 8'h00, d);
      chk(d, e);
   end
   endtask
   task t_status;
   begin
      aux_line_pin = 1'b1;
      ev = 6'h3F;
      @(posedge clk);
      #1;
      ev = 6'h00;
      repeat (6) @(posedge clk);
      rdc(5'h09, 8'h86);
      rdc(5'h0A, 8'h7B);
      rdc(5'h0A, 8'h00);
      wr(5'h0A, 8'hFF);
      rdc(5'h0A, 8'h80);
      rdc(5'h09, 8'h84);
      ev = 6'h2A;
      @(posedge clk);
      #1;
      ev = 6'h00;
      rdc(5'h0A, 8'hD2);
      rdc(5'h0A, 8'h80);
   end
   endtask
   task t_count;
   begin
      rx_data_available = 1'b1;
      rx_octet_count = 4'hA;
      wr(5'h0F, 8'h0C);
      chk({4'h0, tx_octet_count}, 8'h03);
      rdc(5'h0F, 8'h28);
      rdc(5'h0A, 8'h84);
      rx_data_available = 1'b0;
      rdc(5'h0A, 8'h80);
      rdc(5'h0F, 8'h00);
   end
   endtask
   task t_send;
   begin
      wr(5'h0F, 8'h15);
      repeat (3) @(posedge clk);
      #1;
      chk({7'h0, tx_start}, 8'h00);
      wr(5'h10, 8'h5A);
      chk({7'h0, tx_start}, 8'h01);
      @(posedge clk);
      #1;
      chk({7'h0, tx_start}, 8'h00);
      wr(5'h0F, 8'h03);
      chk({6'h0, tx_decline, tx_start}, 8'h02);
      wr(5'h10, 8'h5A);
      chk({7'h0, tx_start}, 8'h00);
      wr(5'h0F, 8'h01);
      wr(5'h0F, 8'h02);
      wr(5'h10, 8'h5A);
      chk({7'h0, tx_start}, 8'h00);
   end
   endtask
   task t_buf;
   begin
      for (i = 0; i < 15; i = i + 1) begin
         wr(5'h10 + i[4:0], 8'hA5 ^ i[7:0]);
      end
      for (i = 0; i < 15; i = i + 1) begin
         rdc(5'h10 + i[4:0], 8'hA5 ^ i[7:0]);
      end
      eng_idx = 4'hE;
      eng_wdata = 8'h3C;
      eng_we = 1'b1;
      @(posedge clk);
      #1;
      eng_we = 1'b0;
      rdc(5'h1E, 8'h3C);
      rdc(5'h1F, 8'h00);
   end
   endtask
   task wrap_up;
   begin
      if (err_total == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 2000) begin
         err_total = err_total + 1;
         wrap_up;
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      t_status;
      t_count;
      t_send;
      t_buf;
      wrap_up;
   end
endmodule
